// ---- verilog/rcb_bank.sv ----
// Summary of operation
// - ctrl bit 3: 0 auto pulse-frequency/width switching, 1 forced pulse-width
// - ctrl bit 2 connects discharge resistor while converter off; resets to 1
// - ctrl bit 1 set: converter runs only if enable bit and pin both high
// - ctrl bit 0 enables the first converter, subject to pin gating
// - eight-bit read-only configuration memory version, writes ignored
//
// register bank: identification, first converter control, other offsets decoded
// assumes a serial-interface front end presenting one-cycle read/write strobes
// the other converters, regulators and fault logic sit outside this bank
`timescale 1ns/1ps
`include "rcb_regs.svh"
module rcb_bank import rcb_pkg::*; #(
  parameter logic [1:0] DEV_IDENTIFIER = 2'h1,   // arbitrary value
  parameter logic [7:0] CFG_MEM_ID = 8'h5A  // arbitrary value
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic en_pin,
  output logic [7:0] reg_rdata,
  output logic first_conv_on,
  output logic first_conv_forced_pulse_width,
  output logic first_conv_discharge_on
);
  rcb_bank_state_t st_q, st_d;
  logic pin_s;
  logic addr_listed;

  // identifier widths are fixed by the revision register layout
  if ($bits(DEV_IDENTIFIER) != 2 || $bits(CFG_MEM_ID) != 8) begin : g_bad_ident
    $error("identifier parameters do not fit the revision registers");
  end

  // offsets of the map; only three are backed here, the rest read zero
  // so that a host scanning the map sees defined data, never a stale byte
  always_comb begin
    case (reg_addr)
      `RCB_ADDR_DEVICE_REVISION,
      `RCB_ADDR_CFG_MEM_VER,
      `RCB_ADDR_FIRST_BUCK_CTRL,
      `RCB_ADDR_PG_CTRL_A,
      `RCB_ADDR_PG_CTRL_B,
      `RCB_ADDR_PWR_FAULT,
      `RCB_ADDR_SOFT_RESET,
      `RCB_ADDR_TOP_INT_A,
      `RCB_ADDR_TOP_INT_B,
      `RCB_ADDR_SD_INT,
      `RCB_ADDR_LIN_INT,
      `RCB_ADDR_TOP_STATUS,
      `RCB_ADDR_SD_STAT,
      `RCB_ADDR_LIN_STAT,
      `RCB_ADDR_TOP_MASK_A,
      `RCB_ADDR_TOP_MASK_B,
      `RCB_ADDR_SD_MASK,
      `RCB_ADDR_LIN_MASK,
      `RCB_ADDR_LOAD_SEL,
      `RCB_ADDR_LOAD_HI,
      `RCB_ADDR_LOAD_LO: addr_listed = 1'h1;
      default: addr_listed = 1'h0;
    endcase
  end

  rcb_pin_sync u_pin_sync (
    .mclk(mclk),
    .resetn(resetn),
    .pin_async(en_pin),
    .pin_level(pin_s)
  );

  logic first_conv_forced_pulse_width_b, first_conv_discharge_enable, first_conv_pin_gating;
  logic first_conv_enable, conv_run;
  always_comb begin
    first_conv_forced_pulse_width_b = st_q.ctrl[`RCB_BIT_FPWM];
    first_conv_discharge_enable = st_q.ctrl[`RCB_BIT_RDIS];
    first_conv_pin_gating = st_q.ctrl[`RCB_BIT_PIN_GATE];
    first_conv_enable = st_q.ctrl[`RCB_BIT_ENABLE];
    // enable bit
    // the pin is synchronised first, so gating lags the pin by four mclk edges (three stages plus the agreement check)
    conv_run = first_conv_enable & (~first_conv_pin_gating | pin_s);
  end

  always_comb begin
    st_d = st_q;
    if (reg_wr && reg_addr == `RCB_ADDR_FIRST_BUCK_CTRL) begin
      st_d.ctrl = reg_wdata & `RCB_CTRL_WMASK;
    end
    // read data is registered and holds until the next read strobe
    if (reg_rd) begin
      case (reg_addr)
        `RCB_ADDR_DEVICE_REVISION: st_d.rdata = {DEV_IDENTIFIER, `RCB_REVISION_RSVD};
        `RCB_ADDR_CFG_MEM_VER: st_d.rdata = CFG_MEM_ID;
        `RCB_ADDR_FIRST_BUCK_CTRL: st_d.rdata = st_q.ctrl;
        default: st_d.rdata = 8'h00;
      endcase
    end
    st_d.conv_on = conv_run;
    st_d.fpwm = first_conv_forced_pulse_width_b;
    st_d.discharge = first_conv_discharge_enable & ~conv_run;
    if (!resetn) begin
      st_d = '0;
      st_d.ctrl = `RCB_CTRL_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  assign reg_rdata = st_q.rdata;
  assign first_conv_on = st_q.conv_on;
  assign first_conv_forced_pulse_width = st_q.fpwm;
  assign first_conv_discharge_on = st_q.discharge;

  // checks: outputs are registered, so each follows its cause one edge later
  // mode follows bit
  a_mode_follows: assert property (@(posedge mclk) disable iff (!resetn)
    ##1 first_conv_forced_pulse_width == $past(st_q.ctrl[`RCB_BIT_FPWM]))
    else $error("mode output wrong");
  a_mode_auto: assert property (@(posedge mclk) disable iff (!resetn)
    !st_q.ctrl[`RCB_BIT_FPWM] |=> !first_conv_forced_pulse_width)
    else $error("forced mode while bit clear");

  a_discharge_off: assert property (@(posedge mclk) disable iff (!resetn)
    first_conv_discharge_on |-> !first_conv_on)
    else $error("discharge while on");
  a_discharge_on: assert property (@(posedge mclk) disable iff (!resetn)
    (st_q.ctrl[`RCB_BIT_RDIS] && !conv_run) |=> first_conv_discharge_on)
    else $error("discharge missing while off");
  a_discharge_gone: assert property (@(posedge mclk) disable iff (!resetn)
    !st_q.ctrl[`RCB_BIT_RDIS] |=> !first_conv_discharge_on)
    else $error("discharge while bit clear");

  a_gate_pin: assert property (@(posedge mclk) disable iff (!resetn)
    (st_q.ctrl[`RCB_BIT_PIN_GATE] && !pin_s) |=> !first_conv_on)
    else $error("pin gating ignored");
  a_pin_enable: assert property (@(posedge mclk) disable iff (!resetn)
    (st_q.ctrl[`RCB_BIT_ENABLE] && st_q.ctrl[`RCB_BIT_PIN_GATE] && pin_s) |=> first_conv_on)
    else $error("gated converter not on");

  a_enable_bit: assert property (@(posedge mclk) disable iff (!resetn)
    (st_q.ctrl[`RCB_BIT_ENABLE] && !st_q.ctrl[`RCB_BIT_PIN_GATE]) |=> first_conv_on)
    else $error("enable bit ignored");
  a_disable_bit: assert property (@(posedge mclk) disable iff (!resetn)
    !st_q.ctrl[`RCB_BIT_ENABLE] |=> !first_conv_on)
    else $error("converter on while disabled");
  a_ctrl_write: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_wr && reg_addr == `RCB_ADDR_FIRST_BUCK_CTRL)
    |=> st_q.ctrl == ($past(reg_wdata) & `RCB_CTRL_WMASK))
    else $error("control write lost");
  a_ctrl_hold: assert property (@(posedge mclk) disable iff (!resetn)
    !(reg_wr && reg_addr == `RCB_ADDR_FIRST_BUCK_CTRL) |=> $stable(st_q.ctrl))
    else $error("control changed without write");

  a_devid_read: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && reg_addr == `RCB_ADDR_DEVICE_REVISION)
    |=> reg_rdata == {DEV_IDENTIFIER, `RCB_REVISION_RSVD})
    else $error("device identifier wrong");

  a_version_read: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && reg_addr == `RCB_ADDR_CFG_MEM_VER) |=> reg_rdata == CFG_MEM_ID)
    else $error("memory version wrong");
  a_ro_write_ignored: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_wr && reg_addr != `RCB_ADDR_FIRST_BUCK_CTRL) |=> $stable(st_q.ctrl))
    else $error("write to other offset changed control");
  a_rdata_holds: assert property (@(posedge mclk) disable iff (!resetn)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  a_ctrl_read: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && reg_addr == `RCB_ADDR_FIRST_BUCK_CTRL) |=> reg_rdata == $past(st_q.ctrl))
    else $error("control readback wrong");
  a_rsvd_readback: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && reg_addr == `RCB_ADDR_FIRST_BUCK_CTRL) |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved control bits read back set");
  a_listed_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && addr_listed && reg_addr > `RCB_ADDR_FIRST_BUCK_CTRL) |=> reg_rdata == 8'h00)
    else $error("unbacked offset read nonzero");
  a_unlisted_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && !addr_listed) |=> reg_rdata == 8'h00)
    else $error("unlisted offset read nonzero");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn)
    st_q.ctrl[7:4] == 4'h0)
    else $error("reserved bits set");

  c_forced_mode: cover property (@(posedge mclk) first_conv_forced_pulse_width);
  c_conv_running: cover property (@(posedge mclk) first_conv_on);
  c_discharging: cover property (@(posedge mclk) first_conv_discharge_on);
  c_pin_gated_on: cover property (@(posedge mclk)
    st_q.ctrl[`RCB_BIT_PIN_GATE] && pin_s && first_conv_on);
  c_unlisted_read: cover property (@(posedge mclk) reg_rd && !addr_listed);
endmodule // rcb_bank

// ---- verilog/rcb_regs.svh ----
// register offsets, field positions, reset values for the regulator control bank
// assumes 8-bit register address space reached through the serial interface
`ifndef RCB_REGS_SVH
`define RCB_REGS_SVH
`define RCB_ADDR_DEVICE_REVISION 8'h00
`define RCB_ADDR_CFG_MEM_VER 8'h01
`define RCB_ADDR_FIRST_BUCK_CTRL 8'h02
`define RCB_ADDR_PG_CTRL_A 8'h15
`define RCB_ADDR_PG_CTRL_B 8'h16
`define RCB_ADDR_PWR_FAULT 8'h17
`define RCB_ADDR_SOFT_RESET 8'h18
`define RCB_ADDR_TOP_INT_A 8'h19
`define RCB_ADDR_TOP_INT_B 8'h1A
`define RCB_ADDR_SD_INT 8'h1B
`define RCB_ADDR_LIN_INT 8'h1C
`define RCB_ADDR_TOP_STATUS 8'h1D
`define RCB_ADDR_SD_STAT 8'h1E
`define RCB_ADDR_LIN_STAT 8'h1F
`define RCB_ADDR_TOP_MASK_A 8'h20
`define RCB_ADDR_TOP_MASK_B 8'h21
`define RCB_ADDR_SD_MASK 8'h22
`define RCB_ADDR_LIN_MASK 8'h23
`define RCB_ADDR_LOAD_SEL 8'h24
`define RCB_ADDR_LOAD_HI 8'h25
`define RCB_ADDR_LOAD_LO 8'h26
`define RCB_BIT_FPWM 3
`define RCB_BIT_RDIS 2
`define RCB_BIT_PIN_GATE 1
`define RCB_BIT_ENABLE 0
`define RCB_CTRL_WMASK 8'h0F
`define RCB_CTRL_RESET 8'h07
`define RCB_REVISION_RSVD 6'h02
`endif

// ---- verilog/rcb_pkg.sv ----
// types shared by the regulator control bank
package rcb_pkg;
  typedef struct packed {
    logic [2:0] sync;
    logic pin;
  } rcb_sync_state_t;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic conv_on;
    logic fpwm;
    logic discharge;
  } rcb_bank_state_t;
endpackage

// ---- verilog/rcb_pin_sync.sv ----
// three-stage synchroniser for the external enable pin
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
module rcb_pin_sync import rcb_pkg::*; (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic pin_async,
  output logic pin_level
);
  rcb_sync_state_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    st_d.sync = {st_q.sync[1:0], pin_async};
    // the first stage feeds only the second; change accepted when stages 2 and 3 agree
    if (st_q.sync[2] == st_q.sync[1]) begin
      st_d.pin = st_q.sync[2];
    end
    if (!resetn) begin
      st_d = '0;
    end
  end
  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end
  assign pin_level = st_q.pin;
endmodule // rcb_pin_sync

// ---- dv/rcb_host_model.sv ----
// host model: issues one-cycle register strobes toward the bank
// assumes it shares mclk with the bank and starts after reset release
`timescale 1ns/1ps
module rcb_host_model (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_wdata = 8'h00;
  end
  // released bus shows the inverse so a stale value never passes for a match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule // rcb_host_model

// ---- dv/regulator_control_register_bank_tb.sv ----
// bench: identification, control bits and pin gating of the bank
// assumes default identifier parameters of the bank
`timescale 1ns/1ps
`include "rcb_regs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module regulator_control_register_bank_tb;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic en_pin = 1'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic reg_wr, reg_rd, first_conv_on, first_conv_forced_pulse_width, first_conv_discharge_on;
  int num_errors = 0;
  int cmp_count = 0;
  initial begin
    forever #5 mclk = ~mclk;
  end
  rcb_bank i_dut (.mclk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .en_pin,
    .reg_rdata, .first_conv_on, .first_conv_forced_pulse_width, .first_conv_discharge_on);
  rcb_host_model i_host (.mclk, .reg_rdata, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
  task automatic complete_run;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic rdchk(string n, logic [7:0] a, logic [7:0] e);
    i_host.rd(a, v);
    `CHK(n, e, v)
  endtask
  // outputs settle one cycle after the write lands
  task automatic outs(logic [2:0] e);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("on/fpwm/dis", e, {first_conv_on, first_conv_forced_pulse_width, first_conv_discharge_on})
  endtask
  task automatic t_ident;
    rdchk("rev", `RCB_ADDR_DEVICE_REVISION, {2'h1, 6'h02});
    rdchk("ver", `RCB_ADDR_CFG_MEM_VER, 8'h5A);
    rdchk("ctrl", `RCB_ADDR_FIRST_BUCK_CTRL, 8'h07);
    outs(3'h1);
    i_host.wr(`RCB_ADDR_DEVICE_REVISION, 8'hFF);
    i_host.wr(`RCB_ADDR_CFG_MEM_VER, 8'h00);
    rdchk("rev wr", `RCB_ADDR_DEVICE_REVISION, {2'h1, 6'h02});
    rdchk("ver wr", `RCB_ADDR_CFG_MEM_VER, 8'h5A);
    rdchk("unmapped", 8'h30, 8'h00);
    $display("test ident done");
  endtask
  task automatic t_ctrl;
    i_host.wr(`RCB_ADDR_FIRST_BUCK_CTRL, 8'hF9);
    outs(3'h6);
    rdchk("ctrl rsvd", `RCB_ADDR_FIRST_BUCK_CTRL, 8'h09);
    i_host.wr(`RCB_ADDR_FIRST_BUCK_CTRL, 8'h04);
    outs(3'h1);
    i_host.wr(`RCB_ADDR_FIRST_BUCK_CTRL, 8'h00);
    outs(3'h0);
    $display("test ctrl done");
  endtask
  task automatic t_pin;
    i_host.wr(`RCB_ADDR_FIRST_BUCK_CTRL, 8'h03);
    outs(3'h0);
    @(posedge mclk);
    en_pin <= 1'h1;
    for (int i = 0; i < 10 && first_conv_on !== 1'h1; i++) @(posedge mclk);
    #1;
    `CHK("pin on", 1'h1, first_conv_on)
    if (first_conv_on !== 1'h1) complete_run();
    @(posedge mclk);
    en_pin <= 1'h0;
    i_host.wr(`RCB_ADDR_FIRST_BUCK_CTRL, 8'h01);
    repeat (8) @(posedge mclk);
    outs(3'h4);
    $display("test pin done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'h1;
    t_ident();
    t_ctrl();
    t_pin();
    complete_run();
  end
endmodule // regulator_control_register_bank_tb
